// ---- verilog/cbc_pkg.sv ----
// Constants, codes and types shared by the bus command controller.
// Assumes a single 25 MHz clock and status codes coming straight from the processor pins.
package cbc_pkg;

  // ==========================================================================
  // Processor status codes, order {bit2, bit1, bit0}
  localparam logic [2:0] STS_IRQ_ACK = 3'h0;
  localparam logic [2:0] STS_IO_READ = 3'h1;
  localparam logic [2:0] STS_IO_WRITE = 3'h2;
  localparam logic [2:0] STS_HALT = 3'h3;
  localparam logic [2:0] STS_CODE_READ = 3'h4;
  localparam logic [2:0] STS_MEM_READ = 3'h5;
  localparam logic [2:0] STS_MEM_WRITE = 3'h6;
  localparam logic [2:0] STS_PASSIVE = 3'h7;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int GRANT_MIN_NS = 110;
  localparam int GRANT_MAX_NS = 250;
  localparam int GRANT_MIN_CYC = (GRANT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GRANT_MAX_CYC = GRANT_MAX_NS / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 3;
  // Pin synchroniser plus the output register already give SYNC_STAGES + 1 cycles
  localparam int GRANT_EXTRA_CYC = (GRANT_MIN_CYC > SYNC_STAGES + 1) ?
                                   (GRANT_MIN_CYC - SYNC_STAGES - 1) : 0;
  localparam logic [2:0] STRAP_CATCH_CYC = 3'h4;

  // ==========================================================================
  // Register map (word index on the register port)
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_CYCLES = 2'h2;
  localparam int CTRL_CMD_EN_BIT = 0;
  localparam int CTRL_CASCADE_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int STAT_PHASE_LSB = 0;
  localparam int STAT_TYPE_LSB = 2;
  localparam int STAT_IO_MODE_BIT = 5;
  localparam int STAT_MEM_GATE_BIT = 6;
  localparam int STAT_IO_GATE_BIT = 7;
  localparam int STAT_STRAP_BIT = 8;
  localparam int STAT_GRANT_BIT = 9;

  // ==========================================================================
  // Pin synchroniser vector {cmd_qualifier, bus_grant_n, io_bus_strap, status[2:0]}
  localparam int SYN_W = 6;
  localparam logic [5:0] SYN_RESET = 6'h17;

  typedef enum logic [1:0] {
    CBC_IDLE = 2'b00,
    CBC_ADDR = 2'b01,
    CBC_CMD = 2'b10,
    CBC_LATE = 2'b11
  } cbc_phase_e;

endpackage : cbc_pkg

// ---- verilog/cbc_bus_cmd_ctrl.sv ----
// Bus command controller: decodes processor status into memory, I/O and
// interrupt-acknowledge commands plus latch, transceiver and cascade controls.
// Assumes all pins are asynchronous to i_clk and that the register port is
// driven from logic on i_clk. Command tri-state is expressed by output enables.
//
// Contract
// R1 - 0 ack, 1/2 io read/write, 3 halt, 4/5 mem read, 6 mem write, 7 passive
// R2 - Advanced memory write is low-active and starts with read commands
// R3 - Memory write command goes low to make memory capture data
// R4 - Memory read command goes low to make memory drive data
// R5 - Interrupt acknowledge goes low like an I/O read
// R6 - Strap low: shared output is high-active cascade enable in acknowledge cycles
// R7 - Strap high: shared output is low-active peripheral data enable
// R8 - I/O bus mode: I/O and acknowledge commands enabled regardless of grant
// R9 - I/O bus mode: I/O commands start at once, peripheral enable and direction steer
// R10 - I/O bus mode: memory commands still wait for bus grant low
// R11 - System bus mode: no command until fixed delay after grant goes low
// R12 - System bus mode: memory and I/O commands both wait for grant
// R13 - Arbiter drives grant low only when the shared bus is free
// R14 - Advanced writes start early in the machine cycle
// R15 - Transceiver enable marks when external bus joins local bus
// R16 - Direction output selects transceiver transfer direction
// R17 - Interrupt sequence is two acknowledge cycles, first without transfers
// R18 - Outside logic masks cascade enable during the first acknowledge cycle
// R19 - Cascade enable asserted before second acknowledge, captured by address strobe
// R20 - Address latch strobe pulses once each machine cycle
// R21 - Qualifier high: commands generated normally
// R22 - Qualifier low: commands driven inactive, not released
// R23 - System mode: commands enabled 110 to 250 ns after grant low
// R24 - Grant inactive releases affected command drivers at once; here the enables drop 4 to 5 cycles later, through the synchroniser
// R25 - Direction high for writes, low for reads
// R26 - Address latch strobe high-active, latching on falling edge
// R27 - Cycle starts when status leaves passive, command ends on passive
`timescale 1ns/1ps
`default_nettype none

module cbc_bus_cmd_ctrl (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cpu_status_bit0,
  input wire logic i_cpu_status_bit1,
  input wire logic i_cpu_status_bit2,
  input wire logic i_bus_grant_n,
  input wire logic i_cmd_qualifier,
  input wire logic i_io_bus_strap,
  input wire logic [1:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata,
  output logic o_mem_read_cmd_n,
  output logic o_mem_write_cmd_n,
  output logic o_adv_mem_write_cmd_n,
  output logic o_io_read_cmd_n,
  output logic o_io_write_cmd_n,
  output logic o_adv_io_write_cmd_n,
  output logic o_irq_ack_cmd_n,
  output logic o_mem_cmd_oe,
  output logic o_io_cmd_oe,
  output logic o_addr_latch_strobe,
  output logic o_xcvr_enable,
  output logic o_xfer_direction,
  output logic o_cascade_or_periph_en
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [cbc_pkg::SYN_W-1:0] sy1;
    logic [cbc_pkg::SYN_W-1:0] sy2;
    logic [cbc_pkg::SYN_W-1:0] sy3;
    logic [cbc_pkg::SYN_W-1:0] flt;
    logic [2:0] boot_cnt;
    logic strap_caught;
    logic io_mode;
    logic [2:0] grant_cnt;
    logic mem_gate;
    logic io_gate;
    cbc_pkg::cbc_phase_e phase;
    logic [2:0] cyc_type;
    logic [1:0] ctrl;
    logic [15:0] cycles;
    logic [15:0] rdata;
    logic mem_read_cmd_n;
    logic mem_write_cmd_n;
    logic adv_mem_write_cmd_n;
    logic io_read_cmd_n;
    logic io_write_cmd_n;
    logic adv_io_write_cmd_n;
    logic irq_ack_cmd_n;
    logic addr_latch;
    logic xcvr_enable;
    logic xfer_direction;
    logic cascade_or_periph_en;
  } cbc_state_s;

  localparam cbc_state_s RESET_STATE = '{
    sy1: cbc_pkg::SYN_RESET,
    sy2: cbc_pkg::SYN_RESET,
    sy3: cbc_pkg::SYN_RESET,
    flt: cbc_pkg::SYN_RESET,
    boot_cnt: 3'h0,
    strap_caught: 1'b0,
    io_mode: 1'b0,
    grant_cnt: 3'h0,
    mem_gate: 1'b0,
    io_gate: 1'b0,
    phase: cbc_pkg::CBC_IDLE,
    cyc_type: cbc_pkg::STS_PASSIVE,
    ctrl: cbc_pkg::CTRL_RESET,
    cycles: 16'h0000,
    rdata: 16'h0000,
    mem_read_cmd_n: 1'b1,
    mem_write_cmd_n: 1'b1,
    adv_mem_write_cmd_n: 1'b1,
    io_read_cmd_n: 1'b1,
    io_write_cmd_n: 1'b1,
    adv_io_write_cmd_n: 1'b1,
    irq_ack_cmd_n: 1'b1,
    addr_latch: 1'b0,
    xcvr_enable: 1'b0,
    xfer_direction: 1'b1,
    cascade_or_periph_en: 1'b0
  };

  cbc_state_s q;
  cbc_state_s next_q;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic [cbc_pkg::SYN_W-1:0] differ;
    logic [2:0] status_f;
    logic grant_low;
    logic qual;
    logic passive;
    logic gate_ok;
    logic data_phase;
    logic late_phase;
    logic is_mem;
    logic is_io;
    logic is_write;
    logic mem_go;
    logic io_go;
    logic cyc_start;
    logic cyc_clear;
    differ = '0;
    status_f = 3'h0;
    grant_low = 1'b0;
    qual = 1'b0;
    passive = 1'b0;
    gate_ok = 1'b0;
    data_phase = 1'b0;
    late_phase = 1'b0;
    is_mem = 1'b0;
    is_io = 1'b0;
    is_write = 1'b0;
    mem_go = 1'b0;
    io_go = 1'b0;
    cyc_start = 1'b0;
    cyc_clear = 1'b0;
    next_q = q;

    // Pin inputs: three flops, a level is accepted once stages two and three agree
    next_q.sy1 = {i_cmd_qualifier, i_bus_grant_n, i_io_bus_strap,
                  i_cpu_status_bit2, i_cpu_status_bit1, i_cpu_status_bit0};
    next_q.sy2 = q.sy1;
    next_q.sy3 = q.sy2;
    differ = q.sy2 ^ q.sy3;
    next_q.flt = (~differ & q.sy3) | (differ & q.flt);
    status_f = q.flt[2:0];
    grant_low = ~q.flt[4];
    qual = q.flt[5] & q.ctrl[cbc_pkg::CTRL_CMD_EN_BIT];
    passive = (status_f == cbc_pkg::STS_PASSIVE);

    // Strap is caught once, after the synchroniser has settled past reset
    if (!q.strap_caught) begin
      if (q.boot_cnt == cbc_pkg::STRAP_CATCH_CYC) begin
        next_q.strap_caught = 1'b1;
        next_q.io_mode = q.flt[3];
      end else begin
        next_q.boot_cnt = q.boot_cnt + 3'h1;
      end
    end

    // Grant qualification; release follows the first agreed high level
    if (grant_low) begin
      if (q.grant_cnt < 3'(cbc_pkg::GRANT_EXTRA_CYC)) begin
        next_q.grant_cnt = q.grant_cnt + 3'h1;
      end
      gate_ok = (q.grant_cnt >= 3'(cbc_pkg::GRANT_EXTRA_CYC)); // [R11] [R23]
    end else begin
      next_q.grant_cnt = 3'h0;
      gate_ok = 1'b0; // [R24]
    end
    next_q.mem_gate = gate_ok & q.strap_caught; // [R10] [R12] [R13]
    if (q.strap_caught && q.io_mode) begin
      next_q.io_gate = 1'b1; // [R8]
    end else begin
      next_q.io_gate = gate_ok & q.strap_caught; // [R12]
    end

    // Machine cycle sequencing
    case (q.phase)
      cbc_pkg::CBC_IDLE: begin
        if (q.strap_caught && !passive) begin
          next_q.phase = cbc_pkg::CBC_ADDR; // [R27]
          next_q.cyc_type = status_f;
          cyc_start = 1'b1;
        end
      end
      cbc_pkg::CBC_ADDR: begin
        if (passive) begin
          next_q.phase = cbc_pkg::CBC_IDLE;
        end else begin
          next_q.phase = cbc_pkg::CBC_CMD;
        end
      end
      cbc_pkg::CBC_CMD: begin
        if (passive) begin
          next_q.phase = cbc_pkg::CBC_IDLE;
        end else begin
          next_q.phase = cbc_pkg::CBC_LATE;
        end
      end
      cbc_pkg::CBC_LATE: begin
        if (passive) begin
          next_q.phase = cbc_pkg::CBC_IDLE; // [R27]
        end
      end
      default: begin
        next_q.phase = cbc_pkg::CBC_IDLE;
      end
    endcase

    // Cycle type decode
    is_mem = (next_q.cyc_type == cbc_pkg::STS_CODE_READ) ||
             (next_q.cyc_type == cbc_pkg::STS_MEM_READ) ||
             (next_q.cyc_type == cbc_pkg::STS_MEM_WRITE); // [R1]
    is_io = (next_q.cyc_type == cbc_pkg::STS_IRQ_ACK) ||
            (next_q.cyc_type == cbc_pkg::STS_IO_READ) ||
            (next_q.cyc_type == cbc_pkg::STS_IO_WRITE); // [R1]
    is_write = (next_q.cyc_type == cbc_pkg::STS_IO_WRITE) ||
               (next_q.cyc_type == cbc_pkg::STS_MEM_WRITE);
    data_phase = (next_q.phase == cbc_pkg::CBC_CMD) || (next_q.phase == cbc_pkg::CBC_LATE);
    late_phase = (next_q.phase == cbc_pkg::CBC_LATE);
    mem_go = qual & next_q.mem_gate & data_phase; // [R21] [R22]
    io_go = qual & next_q.io_gate & data_phase; // [R9] [R21] [R22]

    // Commands: advanced writes and reads from the first data cycle, normal writes later
    next_q.mem_read_cmd_n = ~(mem_go & ((next_q.cyc_type == cbc_pkg::STS_CODE_READ) ||
                              (next_q.cyc_type == cbc_pkg::STS_MEM_READ))); // [R4]
    next_q.adv_mem_write_cmd_n = ~(mem_go &
                                   (next_q.cyc_type == cbc_pkg::STS_MEM_WRITE)); // [R2] [R14]
    next_q.mem_write_cmd_n = ~(mem_go & late_phase &
                               (next_q.cyc_type == cbc_pkg::STS_MEM_WRITE)); // [R3]
    next_q.io_read_cmd_n = ~(io_go & (next_q.cyc_type == cbc_pkg::STS_IO_READ));
    next_q.adv_io_write_cmd_n = ~(io_go &
                                  (next_q.cyc_type == cbc_pkg::STS_IO_WRITE)); // [R14]
    next_q.io_write_cmd_n = ~(io_go & late_phase &
                              (next_q.cyc_type == cbc_pkg::STS_IO_WRITE));
    next_q.irq_ack_cmd_n = ~(io_go & (next_q.cyc_type == cbc_pkg::STS_IRQ_ACK)); // [R5] [R17]

    // One strobe per machine cycle, falling edge latches address and status
    next_q.addr_latch = (next_q.phase == cbc_pkg::CBC_ADDR); // [R20] [R26]

    // Direction: receive from the address cycle of any cycle but a write, transmit otherwise
    if (next_q.phase != cbc_pkg::CBC_IDLE) begin
      next_q.xfer_direction = is_write; // [R16] [R25]
    end else begin
      next_q.xfer_direction = 1'b1;
    end

    // Transceiver enables; peripheral enable takes I/O cycles in I/O bus mode
    if (q.io_mode) begin
      next_q.xcvr_enable = mem_go & is_mem; // [R15]
      next_q.cascade_or_periph_en = ~(io_go & is_io); // [R7] [R9]
    end else begin
      next_q.xcvr_enable = (mem_go & is_mem) | (io_go & is_io); // [R15]
      next_q.cascade_or_periph_en = (next_q.phase == cbc_pkg::CBC_ADDR) &
                                    (next_q.cyc_type == cbc_pkg::STS_IRQ_ACK) &
                                    q.ctrl[cbc_pkg::CTRL_CASCADE_EN_BIT]; // [R6] [R18] [R19]
    end

    // Register port
    cyc_clear = i_reg_wr && (i_reg_addr == cbc_pkg::REG_CYCLES);
    if (i_reg_wr && (i_reg_addr == cbc_pkg::REG_CTRL)) begin
      next_q.ctrl = i_reg_wdata[1:0];
    end
    if (cyc_start) begin
      next_q.cycles = (cyc_clear ? 16'h0000 : q.cycles) + 16'h0001;
    end else if (cyc_clear) begin
      next_q.cycles = 16'h0000;
    end
    next_q.rdata = 16'h0000;
    if (i_reg_rd) begin
      if (i_reg_addr == cbc_pkg::REG_CTRL) begin
        next_q.rdata = {14'h0000, q.ctrl};
      end else if (i_reg_addr == cbc_pkg::REG_STATUS) begin
        next_q.rdata[cbc_pkg::STAT_PHASE_LSB +: 2] = q.phase;
        next_q.rdata[cbc_pkg::STAT_TYPE_LSB +: 3] = q.cyc_type;
        next_q.rdata[cbc_pkg::STAT_IO_MODE_BIT] = q.io_mode;
        next_q.rdata[cbc_pkg::STAT_MEM_GATE_BIT] = q.mem_gate;
        next_q.rdata[cbc_pkg::STAT_IO_GATE_BIT] = q.io_gate;
        next_q.rdata[cbc_pkg::STAT_STRAP_BIT] = q.strap_caught;
        next_q.rdata[cbc_pkg::STAT_GRANT_BIT] = grant_low;
      end else if (i_reg_addr == cbc_pkg::REG_CYCLES) begin
        next_q.rdata = q.cycles;
      end else begin
        next_q.rdata = 16'h0000;
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= RESET_STATE;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_reg_rdata = q.rdata;
  assign o_mem_read_cmd_n = q.mem_read_cmd_n;
  assign o_mem_write_cmd_n = q.mem_write_cmd_n;
  assign o_adv_mem_write_cmd_n = q.adv_mem_write_cmd_n;
  assign o_io_read_cmd_n = q.io_read_cmd_n;
  assign o_io_write_cmd_n = q.io_write_cmd_n;
  assign o_adv_io_write_cmd_n = q.adv_io_write_cmd_n;
  assign o_irq_ack_cmd_n = q.irq_ack_cmd_n;
  assign o_mem_cmd_oe = q.mem_gate; // [R24]
  assign o_io_cmd_oe = q.io_gate; // [R8] [R24]
  assign o_addr_latch_strobe = q.addr_latch;
  assign o_xcvr_enable = q.xcvr_enable;
  assign o_xfer_direction = q.xfer_direction;
  assign o_cascade_or_periph_en = q.cascade_or_periph_en;

endmodule : cbc_bus_cmd_ctrl

`default_nettype wire

// ---- dv/cbc_bus_cmd_ctrl_checker.sv ----
// Pin-level assertions for the bus command controller.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cbc_bus_cmd_ctrl_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cpu_status_bit0,
  input wire logic i_cpu_status_bit1,
  input wire logic i_cpu_status_bit2,
  input wire logic i_bus_grant_n,
  input wire logic i_cmd_qualifier,
  input wire logic i_io_bus_strap,
  input wire logic o_mem_read_cmd_n,
  input wire logic o_mem_write_cmd_n,
  input wire logic o_adv_mem_write_cmd_n,
  input wire logic o_io_read_cmd_n,
  input wire logic o_io_write_cmd_n,
  input wire logic o_adv_io_write_cmd_n,
  input wire logic o_irq_ack_cmd_n,
  input wire logic o_mem_cmd_oe,
  input wire logic o_io_cmd_oe,
  input wire logic o_addr_latch_strobe,
  input wire logic o_xcvr_enable,
  input wire logic o_xfer_direction,
  input wire logic o_cascade_or_periph_en
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic idle_cmds;
  wire logic sts_idle;
  assign sts_idle = ({i_cpu_status_bit2, i_cpu_status_bit1, i_cpu_status_bit0} ==
      cbc_pkg::STS_PASSIVE);
  assign idle_cmds = o_mem_read_cmd_n && o_mem_write_cmd_n && o_adv_mem_write_cmd_n &&
      o_io_read_cmd_n && o_io_write_cmd_n && o_adv_io_write_cmd_n && o_irq_ack_cmd_n;
  cmd_qual_a: assert property ((!i_cmd_qualifier)[*6] |-> idle_cmds && !o_xcvr_enable)
    else $error("command active while qualifier low");
  grant_max_a: assert property ((!i_bus_grant_n)[*8] |-> o_mem_cmd_oe)
    else $error("memory commands not enabled after grant");
  grant_min_a: assert property ($fell(i_bus_grant_n) && !o_mem_cmd_oe |=>
      (!o_mem_cmd_oe)[*2])
    else $error("memory commands enabled too early");
  grant_drop_a: assert property (i_bus_grant_n[*6] |-> !o_mem_cmd_oe)
    else $error("memory commands not released");
  sys_io_wait_a: assert property ((!i_io_bus_strap && i_bus_grant_n)[*6] |-> !o_io_cmd_oe)
    else $error("io commands enabled without grant");
  io_mode_a: assert property (i_io_bus_strap[*8] |-> o_io_cmd_oe)
    else $error("io commands not enabled in io mode");
  passive_a: assert property (sts_idle[*6] |-> idle_cmds && !o_xcvr_enable)
    else $error("command held after passive status");
  adv_write_a: assert property ($fell(o_mem_write_cmd_n) |-> !o_adv_mem_write_cmd_n)
    else $error("memory write ahead of advanced write");
  dir_tx_a: assert property (!o_mem_write_cmd_n || !o_io_write_cmd_n |-> o_xfer_direction)
    else $error("direction low during write");
  strobe_pulse_a: assert property ($rose(o_addr_latch_strobe) |=> !o_addr_latch_strobe)
    else $error("address strobe longer than one cycle");
  cascade_ale_a: assert property (!i_io_bus_strap && o_cascade_or_periph_en |->
      o_addr_latch_strobe)
    else $error("cascade enable outside strobe");
endmodule : cbc_bus_cmd_ctrl_checker
bind cbc_bus_cmd_ctrl cbc_bus_cmd_ctrl_checker u_chk (.*);
`default_nettype wire

// ---- dv/cbc_cpu_arb_model.sv ----
// Far side: processor status driver and bus arbiter.
// Assumes the bench calls its tasks; pins change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module cbc_cpu_arb_model (
  input wire logic i_clk,
  input wire logic i_cascade_or_periph_en,
  output logic o_cpu_status_bit0,
  output logic o_cpu_status_bit1,
  output logic o_cpu_status_bit2,
  output var logic o_bus_grant_n
);
  logic [2:0] sts = cbc_pkg::STS_PASSIVE;
  logic second = 1'b0;
  int cascade_used = 0;
  assign {o_cpu_status_bit2, o_cpu_status_bit1, o_cpu_status_bit0} = sts;
  initial o_bus_grant_n = 1'b1;
  // Cascade pulse of the first acknowledge is masked off
  always @(posedge i_clk) if (second && i_cascade_or_periph_en) cascade_used++;
  task automatic start(input logic [2:0] code);
    @(posedge i_clk);
    sts <= code;
  endtask : start
  task automatic stop();
    @(posedge i_clk);
    sts <= cbc_pkg::STS_PASSIVE;
  endtask : stop
  // Grant is given only when the bench declares the shared bus free
  task automatic grant(input logic g);
    @(posedge i_clk);
    o_bus_grant_n <= ~g;
  endtask : grant
  task automatic irq_seq();
    for (int k = 0; k < 2; k++) begin
      second = (k == 1);
      start(cbc_pkg::STS_IRQ_ACK);
      repeat (7) @(posedge i_clk);
      stop();
      repeat (7) @(posedge i_clk);
    end
    second = 1'b0;
  endtask : irq_seq
endmodule : cbc_cpu_arb_model
`default_nettype wire

// ---- dv/tb_cpu_bus_command_controller.sv ----
// Self-checking bench for the bus command controller.
// Assumes the package, controller, checker and far-side model compile first.
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_bus_command_controller;
  logic clk, rst_n, qual, strap, wr, rd;
  logic [1:0] addr;
  logic [15:0] wdata;
  wire logic [15:0] rdata;
  wire logic mr, mw, amw, ior, iow, aiow, ack, mem_oe, io_oe, ale, xcvr, dir, shared;
  wire logic s0, s1, s2, gnt_n;
  wire logic [6:0] cmd;
  int errors = 0;
  int cmp_count = 0;
  int n_ale = 0;
  int n_mce = 0;
  logic [6:0] exp_cmd [0:7] = '{7'h7E, 7'h77, 7'h79, 7'h7F, 7'h3F, 7'h3F, 7'h4F, 7'h7F};
  assign cmd = {mr, mw, amw, ior, iow, aiow, ack};
  cbc_bus_cmd_ctrl dut (.i_clk(clk), .i_rst_n(rst_n), .i_cpu_status_bit0(s0),
    .i_cpu_status_bit1(s1), .i_cpu_status_bit2(s2), .i_bus_grant_n(gnt_n),
    .i_cmd_qualifier(qual), .i_io_bus_strap(strap), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_mem_read_cmd_n(mr),
    .o_mem_write_cmd_n(mw), .o_adv_mem_write_cmd_n(amw), .o_io_read_cmd_n(ior),
    .o_io_write_cmd_n(iow), .o_adv_io_write_cmd_n(aiow), .o_irq_ack_cmd_n(ack),
    .o_mem_cmd_oe(mem_oe), .o_io_cmd_oe(io_oe), .o_addr_latch_strobe(ale),
    .o_xcvr_enable(xcvr), .o_xfer_direction(dir), .o_cascade_or_periph_en(shared));
  cbc_cpu_arb_model cpu (.i_clk(clk), .i_cascade_or_periph_en(shared),
    .o_cpu_status_bit0(s0), .o_cpu_status_bit1(s1), .o_cpu_status_bit2(s2),
    .o_bus_grant_n(gnt_n));
  // ==========================================================================
  // Clock, pulse counters, shared tasks
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    n_ale += ale;
    n_mce += (shared && !strap);
  end
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic do_reset(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : do_reset
  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [1:0] a, input logic [15:0] exp, input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(nm, exp, rdata);
  endtask : reg_rd
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle
  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    reg_rd(cbc_pkg::REG_CTRL, 16'h0003, "ctrl reset");
    reg_wr(cbc_pkg::REG_CTRL, 16'hFFFE);
    reg_rd(cbc_pkg::REG_CTRL, 16'h0002, "ctrl write");
    reg_wr(2'h3, 16'hFFFF);
    reg_rd(2'h3, 16'h0000, "unmapped");
    reg_wr(cbc_pkg::REG_CTRL, 16'h0003);
  endtask : t_regs
  task automatic t_decode();
    int a0;
    cpu.grant(1'b1);
    reg_wr(cbc_pkg::REG_CYCLES, 16'h0000);
    a0 = n_ale;
    for (int c = 0; c < 7; c++) begin
      cpu.start(3'(c));
      settle(8);
      check("cmd", exp_cmd[c], cmd);
      if (exp_cmd[c] != 7'h7F) begin
        check("dir xcvr", {c == 2 || c == 6, 1'b1}, {dir, xcvr});
      end
      cpu.stop();
      settle(8);
      check("idle", 16'h00FF, {xcvr, dir, cmd});
    end
    check("strobes", 7, n_ale - a0);
    reg_rd(cbc_pkg::REG_CYCLES, 16'h0007, "cycles");
  endtask : t_decode
  task automatic t_qual();
    @(posedge clk);
    qual <= 1'b0;
    cpu.start(cbc_pkg::STS_MEM_WRITE);
    settle(8);
    check("qual low", 16'h007F, {xcvr, cmd});
    cpu.stop();
    qual <= 1'b1;
    settle(8);
  endtask : t_qual
  task automatic t_irq();
    int a0;
    int m0;
    a0 = n_ale;
    m0 = n_mce;
    cpu.irq_seq();
    check("ack strobes", 2, n_ale - a0);
    check("cascade pulses", 2, n_mce - m0);
    check("cascade used", 1, cpu.cascade_used);
  endtask : t_irq
  task automatic t_grant();
    int n;
    cpu.grant(1'b0);
    cpu.start(cbc_pkg::STS_IO_READ);
    settle(8);
    check("oe no grant", 0, {mem_oe, io_oe});
    cpu.grant(1'b1);
    n = 0;
    while (io_oe !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check("grant delay", 1, n >= 3 && n <= 6);
    settle(2);
    check("io read", 7'h77, cmd);
    cpu.grant(1'b0);
    n = 0;
    while (io_oe !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check("release", 1, n <= 6);
    cpu.stop();
    settle(8);
  endtask : t_grant
  task automatic t_iomode();
    do_reset(1'b1);
    settle(2);
    check("io mode oe", 16'h0001, {mem_oe, io_oe});
    cpu.start(cbc_pkg::STS_IO_WRITE);
    settle(8);
    check("io write", 16'h1E48, {cmd, shared, xcvr, dir, 3'h0});
    cpu.stop();
    settle(8);
    check("periph idle", 1, shared);
    cpu.start(cbc_pkg::STS_MEM_READ);
    settle(8);
    check("mem waits", 0, mem_oe);
    cpu.grant(1'b1);
    settle(10);
    check("mem read", 7'h3F, cmd);
    cpu.stop();
    settle(8);
  endtask : t_iomode
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  initial begin
    #(4000 * 40);
    errors++;
    print_verdict();
  end
  initial begin
    {rst_n, qual, strap, wr, rd, addr, wdata} = {1'b0, 1'b1, 21'h0};
    do_reset(1'b0);
    t_regs();
    t_decode();
    t_qual();
    t_irq();
    t_grant();
    t_iomode();
    print_verdict();
  end
endmodule : tb_cpu_bus_command_controller
`default_nettype wire
